// ===== hw/phy_regs_pkg.sv
// Package for the serial bus PHY base register bank.
// Assumes 8-bit register data and a 4-bit register address.
package phy_regs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_NODE_IDENTITY_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_ROOT_RESET_GAP_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_EXTENSION_PORT_COUNT   = 4'h2;
  localparam logic [3:0] ADDR_SPEED_LATENCY_INFO     = 4'h3;
  localparam logic [3:0] ADDR_LINK_CONTENDER_POWER   = 4'h4;
  localparam logic [3:0] ADDR_EVENT_ENABLE_FLAGS     = 4'h5;
  localparam logic [3:0] ADDR_LEGACY_SPEED_BRIDGE    = 4'h6;
  localparam logic [3:0] ADDR_PAGE_PORT_SELECTOR     = 4'h7;

  // ----------------------------------------------------------------
  // Field positions (bit 7 is the first printed bit position)
  // ----------------------------------------------------------------
  localparam int ROOT_FLAG_BIT         = 1;
  localparam int CABLE_POWER_BIT       = 0;
  localparam int ROOT_HOLDOFF_BIT      = 7;
  localparam int BUS_RESET_REQ_BIT     = 6;
  localparam int PAGE_SELECT_LSB       = 5;
  localparam int PORT_SELECT_LSB       = 0;

  // ----------------------------------------------------------------
  // Reset values and constant fields
  // ----------------------------------------------------------------
  localparam logic [5:0] GAP_COUNT_RESET   = 6'h3f;
  localparam logic [2:0] EXTENDED_SET_CODE = 3'h7;
  localparam logic [3:0] PORT_COUNT_CODE   = 4'h3;
  localparam logic [2:0] LEGACY_SPEED_CODE = 3'h7;
  localparam logic [3:0] REPEATER_DELAY    = 4'h2;
  localparam logic [1:0] LINK_CTRL_RESET   = 2'h2; // Link control set, contender clear
  localparam logic [7:0] REG_ZERO          = 8'h00;

  // Reserved page range; pages 2 to 6 read as zero
  localparam logic [2:0] PAGE_FIRST_RSVD = 3'h2;
  localparam logic [2:0] PAGE_LAST_RSVD  = 3'h6;

  // ----------------------------------------------------------------
  // Long bus reset time
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 125;
  localparam int LONG_RESET_US     = 166;
  localparam int LONG_RESET_CYCLES = LONG_RESET_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Paged window request to the page logic
  typedef struct packed {
    logic [2:0] page;
    logic [3:0] port;
    logic [2:0] index;
  } page_req_t;

endpackage

// ===== hw/phy_page_window.sv
// Paged window data for locations 8h to Fh.
// Assumes the page contents come from the arbiter as flat vectors.
`timescale 1ns/1ns
module phy_page_window (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  // Window select
  input  wire phy_regs_pkg::page_req_t    i_sel,
  // Page 0, 1 and 7 contents, eight bytes each
  input  wire logic [63:0]                i_page0,
  input  wire logic [63:0]                i_page1,
  input  wire logic [63:0]                i_page7,
  // Selected byte, combinational
  output logic [7:0]                      o_data
);

  logic [7:0] page_byte [0:7];

  // ----------------------------------------------------------------
  // Byte pick per page; reserved pages give zero
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_page
      always_comb begin
        if (g == 0) begin
          page_byte[g] = i_page0[8*i_sel.index +: 8];
        end else if (g == 1) begin
          page_byte[g] = i_page1[8*i_sel.index +: 8];
        end else if (g == 7) begin
          page_byte[g] = i_page7[8*i_sel.index +: 8];
        end else begin
          page_byte[g] = phy_regs_pkg::REG_ZERO;
        end
      end
    end
  endgenerate

  // Clock kept for a registered variant; reset blanks the window read
  always_comb begin
    o_data = i_reset ? phy_regs_pkg::REG_ZERO : page_byte[i_sel.page];
  end

endmodule

// ===== hw/phy_base_regs.sv
// Base register bank of a three-port serial bus PHY: eight fixed
// registers at 0h-7h and an eight-page window at 8h-Fh.
// Assumes synchronous inputs from the arbiter core and a single-cycle
// read/write strobe port from the link-side register access logic.
//
// Operation
// - Sixteen locations; 0h-7h always reach the fixed base registers.
// - Locations 8h-Fh show one of eight pages chosen by the page field.
// - Base register layout does not change with the selected page.
// - Reserved registers and fields read zero.
// - Pages 2 to 6 are reserved and read zero.
// - Node address comes from self-identification, invalid until it completes.
// - Root flag clears on bus reset, sets when this node becomes root.
// - Cable power flag follows the cable power sense input.
// - Root holdoff requests root after next bus reset; kept across bus reset.
// - Bus reset request starts a 166 us reset once traffic ends.
// - Bus reset request clears on hardware reset, on bus reset or once the long reset runs.
// - Gap count set by register write or configuration packet.
// - Gap count becomes 3Fh on reset or two bare bus resets.
// - Extended set field reads 111b.
// - Port count field reads three.
// - Legacy speed field reads 111b.
// - Repeater delay field reads 02h.
`timescale 1ns/1ns
module phy_base_regs #(
  parameter int LONG_RESET_CYCLES = phy_regs_pkg::LONG_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  // Register port
  input  wire logic [3:0]                 i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [7:0]                      o_rdata,
  // Arbiter core status
  input  wire logic                       i_bus_reset,
  input  wire logic                       i_self_id_done,
  input  wire logic [5:0]                 i_self_id_addr,
  input  wire logic                       i_became_root,
  input  wire logic                       i_cable_power_sense,
  input  wire logic                       i_traffic_busy,
  input  wire logic [2:0]                 i_power_class_strap,
  // Configuration packet updates
  input  wire logic                       i_cfg_gap_valid,
  input  wire logic [5:0]                 i_cfg_gap,
  input  wire logic                       i_cfg_holdoff_valid,
  input  wire logic                       i_cfg_holdoff,
  // Paged window contents
  input  wire logic [63:0]                i_page0,
  input  wire logic [63:0]                i_page1,
  input  wire logic [63:0]                i_page7,
  // Controls to the arbiter core
  output logic                            o_root_holdoff,
  output logic [5:0]                      o_gap_count,
  output logic                            o_long_reset,
  output logic                            o_node_addr_valid,
  output logic [2:0]                      o_page_select,
  output logic [3:0]                      o_port_select
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RST_IDLE = 3'b001,
    RST_WAIT = 3'b010,
    RST_RUN  = 3'b100
  } reset_state_t;

  reset_state_t state;
  reset_state_t next_state;

  logic [5:0]  node_address_field;
  logic        node_addr_valid;
  logic        root_flag;
  logic        cable_power_flag;
  logic        root_holdoff_flag;
  logic        bus_reset_request;
  logic [5:0]  gap_count;
  logic        gap_touched;      // Gap written since the last bus reset
  logic        prior_bare_reset; // A bus reset has been seen since hardware reset
  logic [1:0]  link_ctrl;        // Link active control and contender
  logic [2:0]  power_class;
  logic [7:0]  event_flags;
  logic [3:0]  legacy_bridge;
  logic [2:0]  page_select;
  logic [3:0]  port_select;
  logic [31:0] reset_count;
  logic        strap_taken;
  logic [7:0]  window_data;
  logic [7:0]  next_rdata;
  logic        wr_base;

  phy_regs_pkg::page_req_t page_sel;

  assign wr_base = i_wr && !i_addr[3];

  // ----------------------------------------------------------------
  // Node identity and root status
  // ----------------------------------------------------------------

  // Address is only trusted after self-identification finishes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      node_address_field <= 6'h00;
      node_addr_valid    <= 1'b0;
    end else if (i_bus_reset) begin
      node_addr_valid <= 1'b0;
    end else if (i_self_id_done) begin
      node_address_field <= i_self_id_addr;
      node_addr_valid    <= 1'b1;
    end
  end

  // Bus reset wins over a stale root indication
  always_ff @(posedge i_clk) begin
    if (i_reset || i_bus_reset) begin
      root_flag <= 1'b0;
    end else if (i_became_root) begin
      root_flag <= 1'b1;
    end
  end

  // Sense input is already synchronous; one register keeps read data clean
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cable_power_flag <= 1'b0;
    end else begin
      cable_power_flag <= i_cable_power_sense;
    end
  end

  // ----------------------------------------------------------------
  // Root holdoff and bus reset request
  // ----------------------------------------------------------------

  // Holdoff survives bus reset so it takes effect in the next tree-ID
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      root_holdoff_flag <= 1'b0;
    end else if (i_cfg_holdoff_valid) begin
      root_holdoff_flag <= i_cfg_holdoff;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_ROOT_RESET_GAP_CONTROL) begin
      root_holdoff_flag <= i_wdata[phy_regs_pkg::ROOT_HOLDOFF_BIT];
    end
  end

  // A write of one sets the request; the bus reset clears it unless a new write lands
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus_reset_request <= 1'b0;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_ROOT_RESET_GAP_CONTROL
                 && i_wdata[phy_regs_pkg::BUS_RESET_REQ_BIT]) begin
      bus_reset_request <= 1'b1;
    end else if (i_bus_reset || state == RST_RUN) begin
      bus_reset_request <= 1'b0;
    end
  end

  // Sequencer for the long bus reset, held off by traffic in progress
  always_comb begin
    case (state)
      RST_IDLE: next_state = bus_reset_request ? RST_WAIT : RST_IDLE;
      RST_WAIT: next_state = !bus_reset_request ? RST_IDLE // Bus reset cancels the wait
                           : i_traffic_busy ? RST_WAIT : RST_RUN;
      RST_RUN:  next_state = (reset_count == 32'(LONG_RESET_CYCLES - 1)) ? RST_IDLE : RST_RUN;
      default:  next_state = RST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= RST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counts the 166 us long reset at the system clock rate
  always_ff @(posedge i_clk) begin
    if (i_reset || state != RST_RUN) begin
      reset_count <= 32'h0000_0000;
    end else begin
      reset_count <= reset_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Gap count
  // ----------------------------------------------------------------

  // Two bus resets in a row with no update fall back to the maximum gap
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gap_count        <= phy_regs_pkg::GAP_COUNT_RESET;
      gap_touched      <= 1'b0;
      prior_bare_reset <= 1'b0;
    end else if (i_cfg_gap_valid) begin
      gap_count   <= i_cfg_gap;
      gap_touched <= 1'b1;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_ROOT_RESET_GAP_CONTROL) begin
      gap_count   <= i_wdata[5:0];
      gap_touched <= 1'b1;
    end else if (i_bus_reset) begin
      gap_touched      <= 1'b0;
      prior_bare_reset <= 1'b1;
      if (!gap_touched && prior_bare_reset) begin
        gap_count <= phy_regs_pkg::GAP_COUNT_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable fields in registers 4h to 7h
  // ----------------------------------------------------------------

  // Power class strap is caught on the first clock after reset release
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      link_ctrl   <= phy_regs_pkg::LINK_CTRL_RESET;
      power_class <= 3'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      power_class <= i_power_class_strap;
      strap_taken <= 1'b1;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_LINK_CONTENDER_POWER) begin
      link_ctrl   <= i_wdata[7:6];
      power_class <= i_wdata[2:0];
    end
  end

  // Event and enable bits kept plainly writable
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      event_flags   <= 8'h00;
      legacy_bridge <= 4'h0;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_EVENT_ENABLE_FLAGS) begin
      event_flags <= i_wdata;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_LEGACY_SPEED_BRIDGE) begin
      legacy_bridge <= i_wdata[4:1];
    end
  end

  // Page and port select; the reserved bit between them is dropped
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      page_select <= 3'h0;
      port_select <= 4'h0;
    end else if (wr_base && i_addr == phy_regs_pkg::ADDR_PAGE_PORT_SELECTOR) begin
      page_select <= i_wdata[phy_regs_pkg::PAGE_SELECT_LSB +: 3];
      port_select <= i_wdata[phy_regs_pkg::PORT_SELECT_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Paged window and read path
  // ----------------------------------------------------------------
  assign page_sel.page  = page_select;
  assign page_sel.port  = port_select;
  assign page_sel.index = i_addr[2:0];

  phy_page_window u_window (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_sel   (page_sel),
    .i_page0 (i_page0),
    .i_page1 (i_page1),
    .i_page7 (i_page7),
    .o_data  (window_data)
  );

  // Base layout is fixed; constant fields and reserved bits are built in here
  always_comb begin
    next_rdata = phy_regs_pkg::REG_ZERO;
    if (i_addr[3]) begin
      next_rdata = window_data;
    end else begin
      case (i_addr[2:0])
        3'h0: next_rdata = {node_address_field, root_flag, cable_power_flag};
        3'h1: next_rdata = {root_holdoff_flag, bus_reset_request, gap_count};
        3'h2: next_rdata = {phy_regs_pkg::EXTENDED_SET_CODE, 1'b0,
                            phy_regs_pkg::PORT_COUNT_CODE};
        3'h3: next_rdata = {phy_regs_pkg::LEGACY_SPEED_CODE, 1'b0,
                            phy_regs_pkg::REPEATER_DELAY};
        3'h4: next_rdata = {link_ctrl, 3'h0, power_class};
        3'h5: next_rdata = event_flags;
        3'h6: next_rdata = {3'h0, legacy_bridge, 1'b0};
        3'h7: next_rdata = {page_select, 1'b0, port_select};
        default: next_rdata = phy_regs_pkg::REG_ZERO;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= phy_regs_pkg::REG_ZERO;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the arbiter core
  // ----------------------------------------------------------------
  assign o_root_holdoff    = root_holdoff_flag;
  assign o_gap_count       = gap_count;
  assign o_long_reset      = (state == RST_RUN);
  assign o_node_addr_valid = node_addr_valid;
  assign o_page_select     = page_select;
  assign o_port_select     = port_select;

endmodule

// ===== test/phy_base_regs_checker.sv
// Concurrent checks on the ports of the PHY base register bank.
// Assumes the single-cycle strobe port and a shortened long reset count.
`timescale 1ns/1ns
module phy_base_regs_checker #(
  parameter int LONG_RESET_CYCLES = 20
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  // Core status and configuration packets
  input  wire logic       i_bus_reset,
  input  wire logic       i_self_id_done,
  input  wire logic       i_traffic_busy,
  input  wire logic       i_cfg_gap_valid,
  input  wire logic [5:0] i_cfg_gap,
  input  wire logic       i_cfg_holdoff_valid,
  // Controls to the core
  input  wire logic       o_root_holdoff,
  input  wire logic [5:0] o_gap_count,
  input  wire logic       o_long_reset,
  input  wire logic       o_node_addr_valid,
  input  wire logic [2:0] o_page_select,
  input  wire logic [3:0] o_port_select
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic [7:0]  wdata_q;
  logic [5:0]  gap_q;
  logic [31:0] run_cnt;
  // Delayed copies keep the properties free of $past on slices
  always_ff @(posedge i_clk) begin
    wdata_q <= i_wdata;
    gap_q   <= i_cfg_gap;
  end
  // Cycles spent so far in the current long reset
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_long_reset) begin
      run_cnt <= 32'h0;
    end else begin
      run_cnt <= run_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_req; i_wr && i_addr == 4'h1 && i_wdata[6]; endsequence
  sequence s_quiet; (!i_traffic_busy && !i_bus_reset) [*3]; endsequence
  property p_rdata_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  property p_ext_codes; i_rd && i_addr == 4'h2 |=> o_rdata == 8'he3; endproperty
  property p_spd_codes; i_rd && i_addr == 4'h3 |=> o_rdata == 8'he2; endproperty
  property p_hw_reset;
    $fell(i_reset) |-> o_gap_count == 6'h3f && !o_root_holdoff && !o_long_reset;
  endproperty
  property p_reg_write;
    i_wr && i_addr == 4'h1 && !i_cfg_gap_valid && !i_cfg_holdoff_valid
      |=> o_gap_count == wdata_q[5:0] && o_root_holdoff == wdata_q[7];
  endproperty
  property p_cfg_gap; i_cfg_gap_valid |=> o_gap_count == gap_q; endproperty
  property p_addr_invalid; i_bus_reset && !i_self_id_done |=> !o_node_addr_valid; endproperty
  property p_page_sel;
    i_wr && i_addr == 4'h7 |=> o_page_select == wdata_q[7:5] && o_port_select == wdata_q[3:0];
  endproperty
  property p_rsvd_page;
    i_rd && i_addr[3] && o_page_select >= 3'h2 && o_page_select <= 3'h6 |=> o_rdata == 8'h00;
  endproperty
  // A request followed by three quiet cycles must start the long reset within one more cycle
  property p_long_start; s_req ##1 s_quiet |-> ##[0:1] o_long_reset; endproperty
  property p_long_hold; i_traffic_busy && !o_long_reset |=> !o_long_reset; endproperty
  property p_long_len; $fell(o_long_reset) |-> run_cnt == LONG_RESET_CYCLES; endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_ext_codes: assert property (p_ext_codes) else $error("bad port count byte");
  a_spd_codes: assert property (p_spd_codes) else $error("bad latency byte");
  a_hw_reset: assert property (p_hw_reset) else $error("bad reset state");
  a_reg_write: assert property (p_reg_write) else $error("gap write lost");
  a_cfg_gap: assert property (p_cfg_gap) else $error("packet gap lost");
  a_addr_invalid: assert property (p_addr_invalid) else $error("address still valid");
  a_page_sel: assert property (p_page_sel) else $error("page select lost");
  a_rsvd_page: assert property (p_rsvd_page) else $error("reserved page not zero");
  a_long_start: assert property (p_long_start) else $error("long reset late");
  a_long_hold: assert property (p_long_hold) else $error("long reset during traffic");
  a_long_len: assert property (p_long_len) else $error("long reset length");
endmodule

bind phy_base_regs phy_base_regs_checker #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) u_checker (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_reset(i_bus_reset),
  .i_self_id_done(i_self_id_done), .i_traffic_busy(i_traffic_busy),
  .i_cfg_gap_valid(i_cfg_gap_valid), .i_cfg_gap(i_cfg_gap),
  .i_cfg_holdoff_valid(i_cfg_holdoff_valid), .o_root_holdoff(o_root_holdoff),
  .o_gap_count(o_gap_count), .o_long_reset(o_long_reset),
  .o_node_addr_valid(o_node_addr_valid), .o_page_select(o_page_select),
  .o_port_select(o_port_select));

// ===== test/link_ctrl_model.sv
// Link-side controller model: register reads, writes and config packets.
// Assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/1ns
module link_ctrl_model (
  // Clock
  input  wire logic       i_clk,
  // Register port
  output logic [3:0]      o_addr,
  output logic [7:0]      o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata,
  // Configuration packet updates
  output logic            o_cfg_gap_valid,
  output logic [5:0]      o_cfg_gap,
  output logic            o_cfg_holdoff_valid,
  output logic            o_cfg_holdoff
);
  // Idle port at time zero
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cfg_gap_valid = 1'b0;
    o_cfg_gap = 6'h00;
    o_cfg_holdoff_valid = 1'b0;
    o_cfg_holdoff = 1'b0;
  end
  // Released lines are inverted so stale values cannot pass for good ones
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
  // Gap or holdoff travels as one config packet; is_gap picks which valid strobe is raised
  task automatic cfg(input logic hold, input logic [5:0] gap, input logic is_gap);
    @(posedge i_clk);
    o_cfg_gap_valid <= is_gap;
    o_cfg_holdoff_valid <= !is_gap;
    o_cfg_gap <= gap;
    o_cfg_holdoff <= hold;
    @(posedge i_clk);
    o_cfg_gap_valid <= 1'b0;
    o_cfg_holdoff_valid <= 1'b0;
  endtask
endmodule

// ===== test/phy_base_regs_bench.sv
// Self-checking bench for the PHY base register bank.
// Assumes the link model drives the register port and config packets.
`timescale 1ns/1ns
module phy_base_regs_bench;
  localparam int RUN_LEN = 20;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_bus_reset = 1'b0;
  logic        i_self_id_done = 1'b0;
  logic [5:0]  i_self_id_addr = 6'h00;
  logic        i_became_root = 1'b0;
  logic        i_cable_power_sense = 1'b0;
  logic        i_traffic_busy = 1'b0;
  logic [63:0] i_page0, i_page1, i_page7;
  logic [3:0]  addr, port;
  logic [7:0]  wdata, rdata;
  logic        wr, rd, gap_v, hold_v, hold, o_root_holdoff, o_long_reset, o_addr_valid;
  logic [5:0]  gap, o_gap_count;
  logic [2:0]  page;
  int          err_count = 0;
  int          samples_checked = 0;

  // Clock at 125 MHz
  always #4 i_clk = ~i_clk;

  link_ctrl_model u_link (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata), .o_cfg_gap_valid(gap_v), .o_cfg_gap(gap), .o_cfg_holdoff_valid(hold_v),
    .o_cfg_holdoff(hold));
  // Short long-reset count keeps the run brief
  phy_base_regs #(.LONG_RESET_CYCLES(RUN_LEN)) u_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_bus_reset(i_bus_reset), .i_self_id_done(i_self_id_done), .i_self_id_addr(i_self_id_addr),
    .i_became_root(i_became_root), .i_cable_power_sense(i_cable_power_sense),
    .i_traffic_busy(i_traffic_busy), .i_power_class_strap(3'h4), .i_cfg_gap_valid(gap_v),
    .i_cfg_gap(gap), .i_cfg_holdoff_valid(hold_v), .i_cfg_holdoff(hold), .i_page0(i_page0),
    .i_page1(i_page1), .i_page7(i_page7), .o_root_holdoff(o_root_holdoff),
    .o_gap_count(o_gap_count), .o_long_reset(o_long_reset), .o_node_addr_valid(o_addr_valid),
    .o_page_select(page), .o_port_select(port));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    u_link.rd(a, d);
    check(d & mask, exp);
  endtask
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask
  task automatic pulse_bus_reset;
    @(posedge i_clk);
    i_bus_reset <= 1'b1;
    @(posedge i_clk);
    i_bus_reset <= 1'b0;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] base;
    // Page bytes carry their page and index so a wrong page shows
    for (int k = 0; k < 8; k++) begin
      i_page0[8*k+:8] = 8'h80 + 8'(k);
      i_page1[8*k+:8] = 8'h90 + 8'(k);
      i_page7[8*k+:8] = 8'hf0 + 8'(k);
    end
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd_chk(4'h1, 8'hff, 8'h3f);
    rd_chk(4'h2, 8'hff, 8'he3);
    rd_chk(4'h3, 8'hff, 8'he2);
    rd_chk(4'h0, 8'h02, 8'h00);
    u_link.wr(4'h2, 8'h00);
    u_link.wr(4'h3, 8'h00);
    rd_chk(4'h2, 8'hff, 8'he3);
    rd_chk(4'h3, 8'hff, 8'he2);
    u_link.wr(4'h7, 8'hff);
    rd_chk(4'h7, 8'hff, 8'hef);
    // Cable power flag follows the sense input both ways
    i_cable_power_sense <= 1'b1;
    rd_chk(4'h0, 8'h01, 8'h01);
    i_cable_power_sense <= 1'b0;
    rd_chk(4'h0, 8'h01, 8'h00);
    // Self-ID makes this node root at address 2Ah; bus reset undoes it
    i_cable_power_sense <= 1'b1;
    @(posedge i_clk);
    i_self_id_done <= 1'b1;
    i_became_root <= 1'b1;
    i_self_id_addr <= 6'h2a;
    @(posedge i_clk);
    i_self_id_done <= 1'b0;
    i_became_root <= 1'b0;
    rd_chk(4'h0, 8'hff, 8'hab);
    check({7'h0, o_addr_valid}, 8'h01);
    pulse_bus_reset();
    rd_chk(4'h0, 8'h03, 8'h01);
    check({7'h0, o_addr_valid}, 8'h00);
    // Holdoff by packet, gap by write; only a second bare bus reset restores 3Fh
    u_link.cfg(1'b1, 6'h00, 1'b0);
    u_link.wr(4'h1, 8'h85);
    rd_chk(4'h1, 8'hff, 8'h85);
    pulse_bus_reset();
    rd_chk(4'h1, 8'hff, 8'h85);
    pulse_bus_reset();
    rd_chk(4'h1, 8'hff, 8'hbf);
    check({7'h0, o_root_holdoff}, 8'h01);
    u_link.cfg(1'b0, 6'h12, 1'b1);
    rd_chk(4'h1, 8'hff, 8'h92);
    u_link.cfg(1'b0, 6'h00, 1'b0);
    rd_chk(4'h1, 8'hff, 8'h12);
    check({2'h0, o_gap_count}, 8'h12);
    // Long reset on a quiet line: starts promptly and lasts RUN_LEN cycles
    u_link.wr(4'h1, 8'h52);
    for (n = 0; n < 8 && o_long_reset !== 1'b1; n++) tick();
    check({7'h0, o_long_reset}, 8'h01);
    if (o_long_reset !== 1'b1) stop_test();
    n = 0;
    do begin
      tick();
      n++;
    end while (o_long_reset === 1'b1 && n < 200);
    check(8'(n), 8'(RUN_LEN));
    rd_chk(4'h1, 8'hff, 8'h12);
    // Busy traffic holds the request off; a bus reset then cancels it
    i_traffic_busy <= 1'b1;
    u_link.wr(4'h1, 8'h52);
    repeat (6) tick();
    check({7'h0, o_long_reset}, 8'h00);
    rd_chk(4'h1, 8'hff, 8'h52);
    pulse_bus_reset();
    rd_chk(4'h1, 8'hff, 8'h12);
    i_traffic_busy <= 1'b0;
    repeat (5) tick();
    check({7'h0, o_long_reset}, 8'h00);
    // Every page through the window; base register 2h stays put
    for (int p = 0; p < 8; p++) begin
      u_link.wr(4'h7, {3'(p), 1'b0, 4'h3});
      rd_chk(4'h2, 8'hff, 8'he3);
      check({5'h0, page}, 8'(p));
      base = (p == 0) ? 8'h80 : (p == 1) ? 8'h90 : (p == 7) ? 8'hf0 : 8'h00;
      for (int k = 0; k < 8; k++) begin
        rd_chk(4'h8 + 4'(k), 8'hff, (base == 8'h00) ? 8'h00 : base + 8'(k));
      end
    end
    stop_test();
  end
endmodule
